// [core/dma_crc_params.svh]
// Offsets, field positions and reset values of the CRC and channel block
`ifndef DMA_CRC_PARAMS_SVH
`define DMA_CRC_PARAMS_SVH
`define OFS_CRC_CONTROL    32'h0000_0000
`define OFS_CRC_VALUE      32'h0000_0004
`define OFS_CRC_MASK       32'h0000_0008
`define OFS_CHAN_CONTROL   32'h0000_000c
`define CC_WMASK           32'h3900_1fe7
`define CH_WMASK           32'h0000_01f3
`define CC_EN              7
`define CC_APP             6
`define CC_TYP             5
`define CC_WBO             27
`define CH_BUSY            15
`define CH_CHNS            8
`define CH_ON              7
`define CH_AED             6
`define CH_CHN             5
`define CH_AEN             4
`define CH_EDET            2
`define RESET_WORD         32'h0000_0000
`define OWN_CHANNEL        3'h2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// [core/dma_crc_pkg.sv]
// Types shared by the CRC and channel control block
package dma_crc_pkg;
    typedef struct packed {
        logic [31:0] data;
        logic [2:0]  chan;
        logic        last;
    } xfer_s;
    typedef struct packed {
        logic [31:0] data;
        logic [2:0]  chan;
        logic        last;
        logic        toStart;
    } dst_s;
    typedef enum logic [0:0] {
        ST_PASS   = 1'b0,
        ST_APPEND = 1'b1
    } state_e;
endpackage : dma_crc_pkg

// [core/dma_crc_channel.sv]
// CRC engine with channel control and AXI4-Lite register slave
`timescale 1ns/1ps
`include "dma_crc_params.svh"
module dma_crc_channel (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [31:0]          awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [31:0]          araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    input  wire dma_crc_pkg::xfer_s   srcIn,
    input  wire logic                 srcValid,
    output logic                      srcReady,
    output dma_crc_pkg::dst_s         dstOut,
    output logic                      dstValid,
    input  wire logic                 dstReady,
    input  wire logic                 startEvent,
    input  wire logic                 abortEvent,
    input  wire logic                 doneFromLower,
    input  wire logic                 doneFromHigher,
    output logic                      chanOn,
    output logic [1:0]                chanPriority,
    output logic                      blockDone
);
    logic [31:0] ctrl_q, mask_q, crc_q, chan_q;
    logic [31:0] awAddr_q, wData_q;
    logic [3:0]  wStrb_q;
    logic        awHeld_q, wHeld_q;
    logic [1:0]  bResp_q, rResp_q;
    logic        bValid_q, rValid_q;
    logic [31:0] rData_q;
    logic        dstValid_q;
    dma_crc_pkg::dst_s   dst_q;
    dma_crc_pkg::state_e state_q;
    logic        chanOn_q, eventSeen_q;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Write channels taken in either order; answer once both are accepted
    assign awready = !awHeld_q && !bValid_q;
    assign wready  = !wHeld_q && !bValid_q;
    wire awFire = awvalid && awready;
    wire wFire  = wvalid && wready;
    wire [31:0] wrAddr = awHeld_q ? awAddr_q : awaddr;
    wire [31:0] wrRaw  = wHeld_q ? wData_q : wdata;
    wire [3:0]  wrStrb = wHeld_q ? wStrb_q : wstrb;
    wire doWrite = (awHeld_q || awFire) && (wHeld_q || wFire) && !bValid_q;
    wire wrCc  = doWrite && wrAddr == `OFS_CRC_CONTROL;
    wire wrVal = doWrite && wrAddr == `OFS_CRC_VALUE;
    wire wrMsk = doWrite && wrAddr == `OFS_CRC_MASK;
    wire wrCh  = doWrite && wrAddr == `OFS_CHAN_CONTROL;
    wire wrHit = wrCc || wrVal || wrMsk || wrCh;
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[b*8 +: 8] = nw[b*8 +: 8];
        return r;
    endfunction : merge
    wire [31:0] ccMerged = merge(ctrl_q, wrRaw, wrStrb) & `CC_WMASK;
    // Append refused while reordered writes are selected
    wire [31:0] ccNext = ccMerged[`CC_WBO] ?
        (ccMerged & ~(32'h1 << `CC_APP)) : ccMerged;
    wire [31:0] chMerged  = merge(chan_q, wrRaw, wrStrb);
    wire       crcEnable  = ctrl_q[`CC_EN];
    wire       appendMode = ctrl_q[`CC_APP];
    wire       ipMode     = ctrl_q[`CC_TYP];
    wire       wboSel     = ctrl_q[`CC_WBO];
    wire [1:0] byteOrder  = ctrl_q[29:28];
    wire [4:0] polyLen    = ctrl_q[12:8];
    wire [2:0] crcChan    = ctrl_q[2:0];
    // Mask of stages inside the programmed polynomial length
    wire [31:0] lenMask;
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_len
            assign lenMask[gi] = (5'(gi) <= polyLen);
        end
    endgenerate
    wire [31:0] crcRead = ipMode ? {16'h0, ~crc_q[15:0]}
                                 : (crc_q & lenMask);
    wire [31:0] valMerged = merge(crcRead, wrRaw, wrStrb);
    // Bitwise LFSR over one byte, MSB first
    function automatic logic [31:0] lfsrByte(input logic [31:0] c,
                                             input logic [7:0]  d,
                                             input logic [31:0] fbMask,
                                             input logic [4:0]  top,
                                             input logic [31:0] lm);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            fb = r[top] ^ d[i];
            r = ({r[30:0], fb} ^ ({32{fb}} & fbMask & 32'hffff_fffe));
            r = r & lm;
        end
        return r;
    endfunction : lfsrByte
    // End-around carry sum of two 16-bit words
    function automatic logic [15:0] onesAdd(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0, s[16]};
    endfunction : onesAdd
    // Four bytes per beat so the value keeps pace with the stream
    wire [31:0] lfsrStage [5];
    assign lfsrStage[0] = crc_q;
    for (genvar gb = 0; gb < 4; gb++)
    begin : g_byte
        assign lfsrStage[gb + 1] = lfsrByte(lfsrStage[gb],
            srcIn.data[31 - 8 * gb -: 8], mask_q, polyLen, lenMask);
    end
    // Feedback mask never reaches the checksum path
    wire [15:0] ipSum = onesAdd(onesAdd(crc_q[15:0], srcIn.data[31:16]),
                                srcIn.data[15:0]);
    wire [31:0] crcStep = ipMode ? {16'h0, ipSum} : lfsrStage[4];
    wire [31:0] d = srcIn.data;
    wire [31:0] swapped =
        (byteOrder == 2'h1) ? {d[7:0], d[15:8], d[23:16], d[31:24]} :
        (byteOrder == 2'h2) ? {d[15:0], d[31:16]} :
        (byteOrder == 2'h3) ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    wire slotFree  = !dstValid_q || dstReady;
    assign srcReady = (state_q == dma_crc_pkg::ST_PASS) && slotFree;
    wire srcFire   = srcValid && srcReady;
    wire routed    = crcEnable && srcIn.chan == crcChan;
    wire absorb    = routed && appendMode;
    wire [31:0] passData = (routed && wboSel) ? swapped : d;
    wire emitCrc   = (state_q == dma_crc_pkg::ST_APPEND) && slotFree;
    wire dstLoad   = (srcFire && !absorb) || emitCrc;
    dma_crc_pkg::dst_s dstNext;
    assign dstNext = emitCrc ?
        '{data: crcRead, chan: crcChan, last: 1'b1, toStart: 1'b1} :
        '{data: passData, chan: srcIn.chan, last: srcIn.last,
          toStart: 1'b0};
    assign dstValid = dstValid_q;
    assign dstOut   = dst_q;
    wire ownDone = (srcFire && !absorb && srcIn.last
                    && srcIn.chan == `OWN_CHANNEL)
                || (emitCrc && crcChan == `OWN_CHANNEL);
    assign blockDone = ownDone;
    wire chainHit = chan_q[`CH_CHN] && (chan_q[`CH_CHNS] ? doneFromLower
                                                        : doneFromHigher);
    wire eventHit = (startEvent || abortEvent)
                 && (chanOn_q || chan_q[`CH_AED]);
    // Busy holds until the beat already queued has left
    wire ownPending = (dstValid_q && dst_q.chan == `OWN_CHANNEL)
                   || (state_q == dma_crc_pkg::ST_APPEND
                       && crcChan == `OWN_CHANNEL);
    wire chanBusy = chanOn_q || ownPending;
    assign chanOn       = chanOn_q;
    assign chanPriority = chan_q[1:0];
    wire [31:0] chanRead = {16'h0, chanBusy, 6'h0, chan_q[8], chanOn_q,
                            chan_q[6:4], 1'b0, eventSeen_q, chan_q[1:0]};
    wire rdCc  = araddr == `OFS_CRC_CONTROL;
    wire rdVal = araddr == `OFS_CRC_VALUE;
    wire rdMsk = araddr == `OFS_CRC_MASK;
    wire rdCh  = araddr == `OFS_CHAN_CONTROL;
    wire rdHit = rdCc || rdVal || rdMsk || rdCh;
    wire [31:0] rdWord = rdCc ? ctrl_q : rdVal ? crcRead :
                         rdMsk ? mask_q : rdCh ? chanRead : `RESET_WORD;
    assign arready = !rValid_q;
    wire arFire = arvalid && arready;
    assign bvalid = bValid_q;
    assign bresp  = bResp_q;
    assign rvalid = rValid_q;
    assign rdata  = rData_q;
    assign rresp  = rResp_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= `RESET_WORD;
            wData_q  <= `RESET_WORD;
            wStrb_q  <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q  <= `RESP_OKAY;
        end
        else
        begin
            if (awFire)
                awAddr_q <= awaddr;
            if (wFire)
            begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            awHeld_q <= (awHeld_q || awFire) && !doWrite;
            wHeld_q  <= (wHeld_q || wFire) && !doWrite;
            if (doWrite)
            begin
                bValid_q <= 1'b1;
                bResp_q  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bready)
                bValid_q <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rValid_q <= 1'b0;
            rData_q  <= `RESET_WORD;
            rResp_q  <= `RESP_OKAY;
        end
        else if (arFire)
        begin
            rValid_q <= 1'b1;
            rData_q  <= rdWord;
            rResp_q  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rready)
            rValid_q <= 1'b0;
    end
    // Software seed wins over a beat arriving in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `RESET_WORD;
            mask_q <= `RESET_WORD;
            crc_q  <= `RESET_WORD;
        end
        else
        begin
            if (wrCc)
                ctrl_q <= ccNext;
            if (wrMsk)
                mask_q <= merge(mask_q, wrRaw, wrStrb);
            if (wrVal)
                crc_q <= ipMode ? {16'h0, ~valMerged[15:0]}
                                : valMerged;
            else if (srcFire && routed)
                crc_q <= crcStep;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q    <= dma_crc_pkg::ST_PASS;
            dstValid_q <= 1'b0;
            dst_q      <= '0;
        end
        else
        begin
            case (state_q)
                dma_crc_pkg::ST_PASS:
                    if (srcFire && absorb && srcIn.last)
                        state_q <= dma_crc_pkg::ST_APPEND;
                dma_crc_pkg::ST_APPEND:
                    if (emitCrc)
                        state_q <= dma_crc_pkg::ST_PASS;
                default:
                    state_q <= dma_crc_pkg::ST_PASS;
            endcase
            if (dstLoad)
            begin
                dstValid_q <= 1'b1;
                dst_q      <= dstNext;
            end
            else if (dstReady)
                dstValid_q <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chan_q      <= `RESET_WORD;
            chanOn_q    <= 1'b0;
            eventSeen_q <= 1'b0;
        end
        else
        begin
            if (wrCh)
                chan_q <= chMerged & `CH_WMASK;
            if (wrCh)
                chanOn_q <= chMerged[`CH_ON];
            else if (chainHit)
                chanOn_q <= 1'b1;
            else if (ownDone && !chan_q[`CH_AEN])
                chanOn_q <= 1'b0;
            if (eventHit)
                eventSeen_q <= 1'b1;
            else if (ownDone)
                eventSeen_q <= 1'b0;
        end
    end
    property p_no_append_with_reorder;
        ctrl_q[`CC_WBO] |-> !ctrl_q[`CC_APP];
    endproperty
    a_no_append_with_reorder: assert property (p_no_append_with_reorder)
        else $error("append set while reorder selected");
    property p_len_zeroes;
        (rValid_q && !ipMode && $past(arFire && rdVal && !wrCc))
            |-> (rData_q & ~lenMask) == 32'h0;
    endproperty
    a_len_zeroes: assert property (p_len_zeroes)
        else $error("crc read has bits above length");
    property p_ip_upper_zero;
        ipMode |-> crcRead[31:16] == 16'h0;
    endproperty
    a_ip_upper_zero: assert property (p_ip_upper_zero)
        else $error("ip checksum upper half not zero");
    property p_seed;
        (wrVal && !ipMode && wrStrb == 4'hf && !wrCc)
            |=> crc_q == $past(wrRaw);
    endproperty
    a_seed: assert property (p_seed)
        else $error("crc seed not loaded");
    property p_append_silent;
        (srcFire && absorb && !srcIn.last) |=> !$rose(dstValid_q);
    endproperty
    a_append_silent: assert property (p_append_silent)
        else $error("append beat reached destination");
    property p_append_result;
        (srcFire && absorb && srcIn.last)
            |=> state_q == dma_crc_pkg::ST_APPEND ##[1:8]
                (dstValid_q && dst_q.toStart);
    endproperty
    a_append_result: assert property (p_append_result)
        else $error("crc result not written to start");
    property p_pass_through;
        (srcFire && !absorb) |=> dstValid_q && dst_q.data == $past(passData);
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("beat not passed to destination");
    property p_auto_off;
        (ownDone && !chan_q[`CH_AEN] && !wrCh && !chainHit) |=> !chanOn_q;
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("channel not disabled at block end");
    property p_chain;
        (chan_q[`CH_CHN] && chan_q[`CH_CHNS] && doneFromLower && !wrCh)
            |=> chanOn_q;
    endproperty
    a_chain: assert property (p_chain)
        else $error("chain did not enable channel");
    property p_busy;
        chanOn_q |-> chanRead[`CH_BUSY];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy low while enabled");
endmodule : dma_crc_channel

// [verification/dst_sink.sv]
// Destination-side memory model that takes beats and can stall
`timescale 1ns/1ps
module dst_sink (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire dma_crc_pkg::dst_s dstOut,
    input  wire logic              dstValid,
    input  wire logic              slow,
    output logic                   dstReady,
    output dma_crc_pkg::dst_s      lastBeat,
    output logic [7:0]             beatCount
);
    logic phase_q;
    // Alternate-cycle stall makes the design hold its output beat
    assign dstReady = !slow || phase_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase_q   <= 1'b0;
            lastBeat  <= '0;
            beatCount <= 8'h0;
        end
        else
        begin
            phase_q <= !phase_q;
            if (dstValid && dstReady)
            begin
                lastBeat  <= dstOut;
                beatCount <= beatCount + 8'h1;
            end
        end
    end
endmodule : dst_sink

// [verification/tb_top.sv]
// Self-checking bench for the CRC and channel control block
`timescale 1ns/1ps
`include "dma_crc_params.svh"
module tb_top;
    logic [31:0]        awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [31:0]        rdata, rd;
    logic [3:0]         wstrb = 4'hf;
    logic [1:0]         bresp, rresp, chanPriority, rs;
    logic               clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0, srcValid = 1'b0;
    logic               startEvent = 1'b0, abortEvent = 1'b0;
    logic               doneSeen = 1'b0;
    logic               doneFromLower = 1'b0, doneFromHigher = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic               srcReady, dstValid, dstReady, chanOn, blockDone;
    logic [7:0]         beatCount;
    dma_crc_pkg::xfer_s srcIn = '0;
    dma_crc_pkg::dst_s  dstOut, lastBeat;
    int                 err_total = 0, compares = 0;

    always #12.5 clk = ~clk;

    dma_crc_channel dut_u (.clk, .rst, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .srcIn, .srcValid, .srcReady, .dstOut, .dstValid, .dstReady,
        .startEvent, .abortEvent, .doneFromLower, .doneFromHigher,
        .chanOn, .chanPriority, .blockDone);

    dst_sink sink_u (.clk, .rst, .dstOut, .dstValid, .slow, .dstReady,
        .lastBeat, .beatCount);

    task automatic test_done();
        $display("compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bvalid !== 1'b1)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        rs = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rvalid !== 1'b1)
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
        chk(rd, exp);
    endtask : rchk

    task automatic send(input logic [31:0] d, input logic [2:0] ch,
                        input logic l);
        srcIn <= {d, ch, l};
        srcValid <= 1'b1;
        do @(posedge clk); while (srcReady !== 1'b1);
        doneSeen = blockDone;
        srcValid <= 1'b0;
        @(posedge clk);
    endtask : send

    // Bounded wait, then the beat count must match exactly
    task automatic settle(input logic [7:0] n);
        for (int i = 0; i < 40 && beatCount !== n; i++) @(posedge clk);
        chk({24'h0, beatCount}, {24'h0, n});
    endtask : settle

    task automatic pulse(input int k);
        startEvent <= (k == 0);
        abortEvent <= (k == 1);
        doneFromLower <= (k == 2);
        doneFromHigher <= (k == 3);
        @(posedge clk);
        {startEvent, abortEvent, doneFromLower, doneFromHigher} <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // Bit-serial reference, top byte and top bit first
    function automatic logic [31:0] lfsr(input logic [31:0] c,
        input logic [31:0] d, input logic [31:0] m, input int p);
        logic fb;
        for (int i = 31; i >= 0; i--)
        begin
            fb = c[p] ^ d[i];
            c = (c << 1) ^ ({32{fb}} & m & 32'hffff_fffe);
            c[0] = fb;
        end
        return c & ((32'h2 << p) - 32'h1);
    endfunction : lfsr

    task automatic t_regs();
        for (int i = 0; i < 4; i++) rchk(32'(i * 4), 32'h0);
        rchk(32'h10, 32'h0);
        chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
        wr(32'h10, 32'hffff_ffff);
        chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
        wr(`OFS_CRC_CONTROL, 32'hffff_ffff);
        rchk(`OFS_CRC_CONTROL, 32'h3900_1fa7);
    endtask : t_regs

    task automatic t_lfsr();
        logic [7:0] n;
        wr(`OFS_CRC_CONTROL, 32'h0000_0781);
        wr(`OFS_CRC_VALUE, 32'hffff_ffff);
        rchk(`OFS_CRC_VALUE, 32'h0000_00ff);
        wr(`OFS_CRC_MASK, 32'h0000_0005);
        n = beatCount;
        send(32'ha5c3_0f01, 3'h1, 1'b0);
        settle(n + 8'h1);
        chk(lastBeat.data, 32'ha5c3_0f01);
        send(32'h5a5a_5a5a, 3'h4, 1'b0);
        settle(n + 8'h2);
        rchk(`OFS_CRC_VALUE, lfsr(32'hff, 32'ha5c3_0f01, 32'h5, 7));
    endtask : t_lfsr

    task automatic t_order();
        logic [31:0] exp [4];
        logic [7:0]  n;
        exp = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433};
        slow <= 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            wr(`OFS_CRC_CONTROL, {2'b00, 2'(b), 28'h800_0083});
            n = beatCount;
            send(32'h1122_3344, 3'h3, 1'b0);
            settle(n + 8'h1);
            chk(lastBeat.data, exp[b]);
            send(32'h1122_3344, 3'h6, 1'b0);
            settle(n + 8'h2);
            chk(lastBeat.data, 32'h1122_3344);
        end
        slow <= 1'b0;
    endtask : t_order

    task automatic t_append();
        logic [7:0] n;
        wr(`OFS_CRC_CONTROL, 32'h0000_00e5);
        wr(`OFS_CRC_MASK, 32'hffff_ffff);
        wr(`OFS_CRC_VALUE, 32'h1234_abcd);
        rchk(`OFS_CRC_VALUE, 32'h0000_abcd);
        wr(`OFS_CRC_VALUE, 32'h0);
        n = beatCount;
        send(32'h1234_5678, 3'h5, 1'b0);
        send(32'h0001_0002, 3'h5, 1'b1);
        repeat (6) @(posedge clk);
        settle(n + 8'h1);
        chk(lastBeat.data, 32'h0000_9750);
        chk({27'h0, lastBeat.chan, lastBeat.last, lastBeat.toStart},
            32'h0000_0017);
    endtask : t_append

    task automatic t_chan();
        wr(`OFS_CRC_CONTROL, 32'h0);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0083);
        chk({31'h0, chanOn}, 32'h1);
        chk({30'h0, chanPriority}, 32'h3);
        rchk(`OFS_CHAN_CONTROL, 32'h0000_8083);
        send(32'h0, `OWN_CHANNEL, 1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, chanOn}, 32'h0);
        chk({31'h0, doneSeen}, 32'h1);
        rchk(`OFS_CHAN_CONTROL, 32'h0000_0003);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0120);
        pulse(3);
        chk({31'h0, chanOn}, 32'h0);
        pulse(2);
        chk({31'h0, chanOn}, 32'h1);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0100);
        pulse(2);
        chk({31'h0, chanOn}, 32'h0);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0020);
        pulse(2);
        chk({31'h0, chanOn}, 32'h0);
        pulse(3);
        chk({31'h0, chanOn}, 32'h1);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0090);
        send(32'h0, `OWN_CHANNEL, 1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, chanOn}, 32'h1);
        wr(`OFS_CHAN_CONTROL, 32'h0);
        pulse(0);
        rchk(`OFS_CHAN_CONTROL, 32'h0);
        wr(`OFS_CHAN_CONTROL, 32'h0000_0040);
        pulse(1);
        rchk(`OFS_CHAN_CONTROL, 32'h0000_0044);
    endtask : t_chan

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_lfsr();
        t_order();
        t_append();
        t_chan();
        test_done();
    end

    // The full sequence needs well under a thousand cycles
    initial
    begin
        #200us;
        err_total++;
        test_done();
    end
endmodule : tb_top
